// ===== src/qafc_pkg.sv
/*
 * Constants for the serial frame and conversion sequencing block of a
 * four-channel 12-bit converter.
 * Assumes the includer imports the whole package.
 */
package qafc_pkg;
    localparam int CODE_W = 12;
    localparam int NUM_CHAN = 4;
    localparam int CTRL_W = 8;
    localparam int CNT_W = 4;
    // Falling-edge count positions within one 16-clock conversion
    localparam logic [3:0] CNT_IDLE = 4'h0;
    localparam logic [3:0] CNT_TRACK_FIRST = 4'h1;
    localparam logic [3:0] CNT_TRACK_LAST = 4'h3;
    localparam logic [3:0] CNT_HOLD = 4'h4;
    localparam logic [3:0] CNT_LAST_BIT = 4'hF;
    // Rising edge on which the control word is complete
    localparam logic [3:0] CNT_CTRL_LAST = 4'h8;
    // Channel address field of the control word
    localparam int CHAN_LSB = 3;
    localparam int CHAN_DEC_W = 2;
    localparam logic [1:0] CHAN_RESET = 2'h0;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [7:0] CTRL_RESET = 8'h00;
endpackage : qafc_pkg

// ===== src/qafc_sync.sv
/*
 * Two-flop level synchroniser, parameterised width.
 * Assumes each bit is a level, or a word held stable by a handshake.
 */
`timescale 1ns/100ps
module qafc_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
        end
    end

    assign q_o = s2_r;
endmodule : qafc_sync

// ===== src/qafc_frame_ctrl.sv
/*
 * Serial frame and conversion sequencing of a four-channel 12-bit
 * converter: track/hold phases, result shift-out, control word capture,
 * power-down between frames and conversions, channel code staging.
 * Assumes the host drives frame select, serial clock and control input,
 * and that system-side logic writes the quantised code of each channel.
 */
// What this block does
// R1: Track the selected input during the first three clocks after each conversion start.
// R2: Hold and convert over the next thirteen clocks; conversion lasts sixteen.
// R3: Shift result out MSB first, first bit on the fifth clock.
// R4: Frame runs while select is low; host gives multiples of sixteen rising edges.
// R5: Output high impedance while select high, driven from the first internal falling edge while select low.
// R6: Power down while select high and between consecutive conversions.
// R7: Retrack after falling edge following edge 16N, hold again on fall 16N+4.
// R8: Block the serial clock internally while select is high.
// R9: With clock resting low, select fall acts as first internal falling edge.
// R10: With clock resting high, track begins on first clock fall after select.
// R11: Sample control input on the first eight rising edges of each conversion.
// R12: Host sends the control word for the following conversion, not the current.
// R13: Convert right after power-up; first conversion samples input one.
// R14: Channel address sits in control bits five to three, used next conversion.
// R15: Decode only the two low address bits; top address bit ignored.
// R16: Control bits seven, six and two to zero have no effect.
// R17: Result is a 12-bit straight binary code.
// R18: Host keeps select and clock falls apart, else capture slips one clock.
// R19: Power down from the sixteenth fall until the next conversion's first fall.
// R20: Keep converting back to back while select stays low.
// R21: Drive zero on clocks one to four before the result bits.
// R22: Host shifts the control word MSB first.
`timescale 1ns/100ps
module qafc_frame_ctrl
    import qafc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // System side: quantised code per channel
    input wire logic code_wr_i,
    input wire logic [1:0] code_chan_i,
    input wire logic [CODE_W-1:0] code_data_i,
    output logic frame_active_o,
    output logic code_staged_o,
    // Link side
    input wire logic sclk_i,
    input wire logic frame_sel_n_i,
    input wire logic ctrl_din_i,
    output logic dout_o,
    output logic dout_oe_n_o,
    // Analog front-end steering, link domain
    output logic track_o,
    output logic power_down_o,
    output logic [1:0] chan_o
);
    // =====================================================================
    // System clock domain: code registers and snapshot handshake
    // =====================================================================
    logic [CODE_W-1:0] code_r [NUM_CHAN];
    logic [NUM_CHAN*CODE_W-1:0] snap_r;
    logic req_r;
    logic ack_sync;
    logic sel_n_sync;
    logic frame_active_r;
    logic staged_r;
    // Link-side acknowledge toggle, read here through u_sync_ack
    logic ack_r;
    wire snap_free = (ack_sync == req_r);
    wire [NUM_CHAN*CODE_W-1:0] code_flat;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi++) begin : g_code
            wire wr_hit = code_wr_i && (code_chan_i == 2'(gi));
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    code_r[gi] <= CODE_RESET;
                end else if (wr_hit) begin
                    code_r[gi] <= code_data_i; // R17
                end
            end
            assign code_flat[gi*CODE_W +: CODE_W] = code_r[gi];
        end
    endgenerate

    qafc_sync #(.W(1)) u_sync_ack (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(ack_r),
        .q_o(ack_sync)
    );

    qafc_sync #(.W(1)) u_sync_sel (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(frame_sel_n_i),
        .q_o(sel_n_sync)
    );

    // Snapshot stays frozen until the link side has acknowledged it
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            snap_r <= '0;
            req_r <= 1'b0;
            staged_r <= 1'b0;
        end else begin
            staged_r <= snap_free;
            if (snap_free) begin
                snap_r <= code_flat;
                req_r <= ~req_r;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            frame_active_r <= 1'b0;
        end else begin
            frame_active_r <= ~sel_n_sync;
        end
    end

    assign frame_active_o = frame_active_r;
    assign code_staged_o = staged_r;

    // =====================================================================
    // Link domain: gated serial clock
    // =====================================================================
    // Forced high while select is high, so a select fall with the clock
    // resting low becomes the first falling edge, and with it resting
    // high the first real clock fall is.
    wire gclk = sclk_i | frame_sel_n_i; // R8 R9 R10
    // Frame state clears while select is high; channel survives frames.
    // The clear tests the select pin itself: with the clock resting low,
    // the select fall lifts the clear and makes fall 1 in one instant,
    // and only the pin is sure to be settled when that edge is seen.

    logic [CNT_W-1:0] fcnt_r;
    logic [CNT_W-1:0] fcnt_nxt;
    logic [CODE_W-1:0] shift_r;
    logic dout_r;
    logic oe_n_r;
    logic track_r;
    logic pdn_r;
    logic [1:0] chan_act_r;
    logic [1:0] chan_next_r;
    logic [CTRL_W-2:0] ctrl_sr_r;
    logic req_sync;
    logic [NUM_CHAN*CODE_W-1:0] shadow_r;

    // Wraps 15 -> 0: the value 0 is the power-down gap after fall 16
    assign fcnt_nxt = fcnt_r + 4'h1; // R20
    wire starts_track = (fcnt_nxt == CNT_TRACK_FIRST); // R7
    wire in_track = (fcnt_nxt >= CNT_TRACK_FIRST) && (fcnt_nxt <= CNT_TRACK_LAST);
    wire enter_hold = (fcnt_nxt == CNT_HOLD); // R2 R7
    // Falls 5 to 16 carry bits 11 down to 0
    wire shifting = (fcnt_r >= CNT_HOLD); // R3
    wire [CODE_W-1:0] held_code = shadow_r[chan_act_r*CODE_W +: CODE_W];
    wire [CTRL_W-1:0] ctrl_word = {ctrl_sr_r, ctrl_din_i}; // R22
    // A select rise with the clock low is a rising edge of gclk; never
    // let it latch a half-shifted word as the next channel.
    wire ctrl_done = (fcnt_r == CNT_CTRL_LAST) && !frame_sel_n_i; // R8
    wire ctrl_take = (fcnt_r >= CNT_TRACK_FIRST) && (fcnt_r <= CNT_CTRL_LAST); // R11
    // Fall 4 only loads the held word; its MSB leaves on fall 5
    wire [CODE_W-1:0] shift_nxt = enter_hold ? held_code :
        (shifting ? {shift_r[CODE_W-2:0], 1'b0} : shift_r);
    wire dout_nxt = shifting & shift_r[CODE_W-1]; // R3 R21

    // =====================================================================
    // Link domain: conversion sequencing on falling edges
    // =====================================================================
    always_ff @(negedge gclk or posedge rst_i or posedge frame_sel_n_i) begin
        if (rst_i || frame_sel_n_i) begin
            fcnt_r <= CNT_IDLE; // R4
        end else begin
            fcnt_r <= fcnt_nxt; // R1 R2
        end
    end

    always_ff @(negedge gclk or posedge rst_i or posedge frame_sel_n_i) begin
        if (rst_i || frame_sel_n_i) begin
            track_r <= 1'b0;
        end else begin
            track_r <= in_track; // R1
        end
    end

    always_ff @(negedge gclk or posedge rst_i or posedge frame_sel_n_i) begin
        if (rst_i || frame_sel_n_i) begin
            pdn_r <= 1'b1; // R6
        end else begin
            pdn_r <= (fcnt_nxt == CNT_IDLE); // R6 R19
        end
    end

    always_ff @(negedge gclk or posedge rst_i or posedge frame_sel_n_i) begin
        if (rst_i || frame_sel_n_i) begin
            oe_n_r <= 1'b1; // R5
        end else begin
            oe_n_r <= 1'b0; // R5
        end
    end

    // Zeros on falls 1 to 4, then twelve bits MSB first on falls 5 to 16
    always_ff @(negedge gclk or posedge rst_i or posedge frame_sel_n_i) begin
        if (rst_i || frame_sel_n_i) begin
            shift_r <= CODE_RESET;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    always_ff @(negedge gclk or posedge rst_i or posedge frame_sel_n_i) begin
        if (rst_i || frame_sel_n_i) begin
            dout_r <= 1'b0;
        end else begin
            dout_r <= dout_nxt; // R3 R21
        end
    end

    // Power-up default selects input one
    always_ff @(negedge gclk or posedge rst_i) begin
        if (rst_i) begin
            chan_act_r <= CHAN_RESET; // R13
        end else if (starts_track) begin
            chan_act_r <= chan_next_r; // R14
        end
    end

    // =====================================================================
    // Link domain: control word capture on rising edges
    // =====================================================================
    always_ff @(posedge gclk or posedge rst_i or posedge frame_sel_n_i) begin
        if (rst_i || frame_sel_n_i) begin
            ctrl_sr_r <= CTRL_RESET[CTRL_W-2:0];
        end else if (ctrl_take) begin
            ctrl_sr_r <= ctrl_word[CTRL_W-2:0];
        end
    end

    // Only the two low address bits matter; other bits are dropped
    always_ff @(posedge gclk or posedge rst_i) begin
        if (rst_i) begin
            chan_next_r <= CHAN_RESET;
        end else if (ctrl_done) begin
            chan_next_r <= ctrl_word[CHAN_LSB +: CHAN_DEC_W]; // R14 R15 R16
        end
    end

    // Snapshot only refreshes while the serial clock runs; words written
    // during a long idle gap wait behind the snapshot already pending there, which the next frame takes first.
    qafc_sync #(.W(1)) u_sync_req (
        .clk_i(gclk),
        .rst_i(rst_i),
        .d_i(req_r),
        .q_o(req_sync)
    );

    always_ff @(posedge gclk or posedge rst_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            shadow_r <= '0;
        end else if (req_sync != ack_r) begin
            ack_r <= req_sync;
            shadow_r <= snap_r;
        end
    end

    assign dout_o = dout_r;
    assign dout_oe_n_o = oe_n_r;
    assign track_o = track_r;
    assign power_down_o = pdn_r;
    assign chan_o = chan_act_r;
endmodule : qafc_frame_ctrl

// ===== tb/qafc_checker.sv
/* Checker for qafc_frame_ctrl link pins.
   Assumes sclk rests low or high outside frames, never runs there. */
`timescale 1ns/100ps
module qafc_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic frame_sel_n_i,
    input wire logic ctrl_din_i,
    input wire logic dout_o,
    input wire logic dout_oe_n_o,
    input wire logic track_o,
    input wire logic power_down_o,
    input wire logic [1:0] chan_o
);
    // ====
    // Rising edges seen in the current conversion
    logic [3:0] cnt_r;
    logic [7:0] word_r;
    always_ff @(posedge sclk_i or posedge frame_sel_n_i) begin
        if (frame_sel_n_i) cnt_r <= 4'h0;
        else cnt_r <= cnt_r + 4'h1;
    end
    always_ff @(posedge sclk_i) begin
        if (cnt_r < 4'h8) word_r <= {word_r[6:0], ctrl_din_i};
    end
    a_idle_quiet:
    assert property (@(posedge clk_i) disable iff (rst_i)
        frame_sel_n_i |-> dout_oe_n_o && power_down_o && !track_o && !dout_o)
        else $error("link not quiet outside frame");
    a_oe_frame:
    assert property (@(posedge sclk_i) disable iff (rst_i || frame_sel_n_i)
        !dout_oe_n_o) else $error("output not driven");
    a_zero_lead:
    assert property (@(posedge sclk_i) disable iff (rst_i || frame_sel_n_i)
        cnt_r < 4'h4 |-> !dout_o) else $error("leading bit not zero");
    a_track_phase:
    assert property (@(posedge sclk_i) disable iff (rst_i || frame_sel_n_i)
        track_o == (cnt_r < 4'h3)) else $error("track phase wrong");
    a_pdn_phase:
    assert property (@(posedge sclk_i) disable iff (rst_i || frame_sel_n_i)
        power_down_o == (cnt_r == 4'hF)) else $error("power down wrong");
    a_chan_hold:
    assert property (@(posedge sclk_i) disable iff (rst_i || frame_sel_n_i)
        cnt_r != 4'h0 |-> $stable(chan_o)) else $error("channel moved");
    a_chan_next:
    assert property (@(posedge sclk_i) disable iff (rst_i || frame_sel_n_i)
        cnt_r == 4'hF |=> chan_o == word_r[4:3]) else $error("channel not taken");
endmodule : qafc_checker
bind qafc_frame_ctrl qafc_checker chk (.clk_i, .rst_i, .sclk_i, .frame_sel_n_i,
    .ctrl_din_i, .dout_o, .dout_oe_n_o, .track_o, .power_down_o, .chan_o);

// ===== tb/qafc_host.sv
/* Host serial port model: frames, control words, result capture.
   Assumes the converter answers on its link pins only. */
`timescale 1ns/100ps
module qafc_host (
    output logic sclk_o,
    output logic frame_sel_n_o,
    output logic ctrl_din_o,
    input wire logic dout_i,
    input wire logic dout_oe_n_i
);
    logic [7:0] words [4];
    logic [15:0] res [4];
    logic start_oe;
    // Released line reads inverted, so a wrong enable shows
    wire line = dout_oe_n_i ? ~dout_i : dout_i;
    initial begin
        sclk_o = 1'b0;
        frame_sel_n_o = 1'b1;
        ctrl_din_o = 1'b0;
    end
    task automatic run_frame(input int nconv, input bit hi);
        int i;
        sclk_o = hi;
        #20 frame_sel_n_o = 1'b0;
        #5 start_oe = dout_oe_n_i;
        #1 sclk_o = 1'b0;
        for (i = 0; i < 16 * nconv; i++) begin
            ctrl_din_o = (i % 16 < 8) ? words[i / 16][7 - i % 16] : i[0];
            #6 res[i / 16][15 - i % 16] = line;
            sclk_o = 1'b1;
            if (i < 16 * nconv - 1) #6 sclk_o = 1'b0;
        end
        #6 frame_sel_n_o = 1'b1;
        // Blocked fall, then clock rests low
        #6 sclk_o = 1'b0;
    endtask : run_frame
endmodule : qafc_host

// ===== tb/test_quad_adc_serial_frame_control.sv
/* Testbench for qafc_frame_ctrl driven by the host model.
   Assumes package, design and checker files compile first. */
`timescale 1ns/100ps
module test_quad_adc_serial_frame_control;
    logic clk_i, rst_i, code_wr_i;
    logic [1:0] code_chan_i;
    logic [11:0] code_data_i;
    wire sclk_i, frame_sel_n_i, ctrl_din_i, dout_o, dout_oe_n_o;
    wire track_o, power_down_o, frame_active_o, code_staged_o;
    wire [1:0] chan_o;
    int bad_count, num_checks, cyc;
    logic [11:0] codes [4] = '{12'h0A5C, 12'h03E1, 12'h07F0, 12'h081F};
    qafc_frame_ctrl DUT (.clk_i, .rst_i, .code_wr_i, .code_chan_i, .code_data_i,
        .frame_active_o, .code_staged_o, .sclk_i, .frame_sel_n_i, .ctrl_din_i,
        .dout_o, .dout_oe_n_o, .track_o, .power_down_o, .chan_o);
    qafc_host host (.sclk_o(sclk_i), .frame_sel_n_o(frame_sel_n_i),
        .ctrl_din_o(ctrl_din_i), .dout_i(dout_o), .dout_oe_n_i(dout_oe_n_o));
    // ====
    // Shared steps
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic write_code(input logic [1:0] ch, input logic [11:0] d);
        @(posedge clk_i);
        code_wr_i <= 1'b1;
        code_chan_i <= ch;
        code_data_i <= d;
        @(posedge clk_i);
        code_wr_i <= 1'b0;
    endtask : write_code
    // Odd offset keeps the link unrelated to the system clock
    task automatic frame(input int n, input bit hi);
        @(posedge clk_i);
        #37 host.run_frame(n, hi);
    endtask : frame
    task automatic final_report;
        $display("checks=%0d bad=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    initial forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            final_report();
        end
    end
    // ====
    // Scenarios
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        code_wr_i = 1'b0;
        code_chan_i = 2'h0;
        code_data_i = 12'h000;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        host.words[0] = 8'hF5;
        frame(1, 0);
        cmp(host.res[0], 16'h0000);
        cmp({15'h0, host.start_oe}, 16'h0000);
        cmp({14'h0, chan_o}, 16'h0000);
        for (int c = 0; c < 4; c++) write_code(c[1:0], codes[c]);
        repeat (10) @(posedge clk_i);
        host.words[0] = 8'h18;
        frame(1, 0);
        cmp({14'h0, chan_o}, 16'h0002);
        repeat (10) @(posedge clk_i);
        host.words = '{8'hC8, 8'h27, 8'h10, 8'h18};
        frame(4, 0);
        cmp({15'h0, frame_active_o}, 16'h0001);
        cmp(host.res[0], {4'h0, codes[3]});
        cmp(host.res[1], {4'h0, codes[1]});
        cmp(host.res[2], {4'h0, codes[0]});
        cmp(host.res[3], {4'h0, codes[2]});
        frame(1, 1);
        cmp({15'h0, host.start_oe}, 16'h0001);
        cmp(host.res[0], {4'h0, codes[3]});
        cmp({14'h0, power_down_o, dout_oe_n_o}, 16'h0003);
        repeat (6) @(posedge clk_i);
        cmp({15'h0, frame_active_o}, 16'h0000);
        cmp({15'h0, code_staged_o}, 16'h0000);
        final_report();
    end
endmodule : test_quad_adc_serial_frame_control
